// ==== verilog/rre_core.sv ====
// Executes the return-type and rotate-left-through-carry instructions.
// Assumes instruction words come from logic on clk_in, offered with a valid strobe.
// Assumes the file register memory answers file_addr_out combinationally.
// Assumes push requests come from the call logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "rre_defs.svh"
module rre_core #(
  parameter int PC_W = `RRE_PC_W,
  parameter int DEPTH = `RRE_STACK_DEPTH
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic instr_valid_in,
  input wire logic [`RRE_WORD_W-1:0] instr_word_in,
  input wire logic push_in,
  input wire logic [PC_W-1:0] push_pc_in,
  input wire logic [7:0] file_rd_data_in,
  input wire logic carry_in,
  input wire logic [7:0] irq_control_reg_in,
  output logic instr_ready_out,
  output logic [PC_W-1:0] pc_out,
  output logic pc_load_out,
  output logic [7:0] wreg_out,
  output logic wreg_we_out,
  output logic [6:0] file_addr_out,
  output logic [7:0] file_wr_data_out,
  output logic file_we_out,
  output logic carry_out,
  output logic carry_we_out,
  output logic [7:0] irq_control_reg_out,
  output logic irq_control_we_out,
  output logic [$clog2(DEPTH)-1:0] stack_ptr_out,
  output logic cycle_en_out
);
  import rre_pkg::*;

  localparam int SP_W = $clog2(DEPTH);

  // A word is taken at the edge that ends an instruction cycle and executes at the next
  // such edge; its write strobes stand for the one clock after that edge. Returns spend
  // one more instruction cycle before ready rises, so they cost two cycles in all.

  typedef struct packed {
    logic [1:0] phase;
    rre_state_t state;
    rre_op_t op;
    logic [`RRE_WORD_W-1:0] word;
    logic [SP_W-1:0] sp;
    logic [PC_W-1:0] pc;
    logic pc_load;
    logic [7:0] wreg;
    logic wreg_we;
    logic [6:0] faddr;
    logic [7:0] fdata;
    logic fwe;
    logic carry;
    logic carry_we;
    logic [7:0] irq_ctl;
    logic irq_ctl_we;
    logic ready;
    logic cyc_en;
  } rre_state_s_t;

  rre_state_s_t st_r;
  rre_state_s_t st_nxt;
  // Return addresses; the pointer wraps, so a pop of an empty stack reads stale data.
  logic [PC_W-1:0] stack_r [DEPTH];

  // The two return words are exact matches; the literal and rotate forms match their
  // upper six bits only. Any other word runs as a one-cycle no-operation.
  function automatic rre_op_t decode(input logic [`RRE_WORD_W-1:0] w);
    if (w == `RRE_OP_IRQ_EXIT) begin
      return RRE_IRQ_EXIT;
    end else if (w == `RRE_OP_RETURN) begin
      return RRE_SUB_EXIT;
    end else if (w[13:8] == `RRE_OP_LIT_HI) begin
      return RRE_LIT_EXIT;
    end else if (w[13:8] == `RRE_OP_ROT_HI) begin
      return RRE_ROT;
    end
    return RRE_NONE;
  endfunction

  always_comb begin
    logic [SP_W-1:0] top;
    logic [8:0] rot;
    top = st_r.sp - SP_W'(1);
    rot = {file_rd_data_in, carry_in};
    st_nxt = st_r;
    st_nxt.pc_load = 1'b0;
    st_nxt.wreg_we = 1'b0;
    st_nxt.fwe = 1'b0;
    st_nxt.carry_we = 1'b0;
    st_nxt.irq_ctl_we = 1'b0;
    // Four clock quarters form one instruction cycle; the enable marks its end.
    st_nxt.phase = st_r.phase + 2'h1;
    st_nxt.cyc_en = (st_r.phase == 2'(`RRE_OSC_PER_CYC - 2));
    // A pop later in this process overrides this increment, so a pop wins a collision
    // and the address pushed in that clock is lost.
    if (push_in) begin
      st_nxt.sp = st_r.sp + SP_W'(1);
    end
    if (st_r.cyc_en) begin
      unique case (st_r.state)
        RRE_IDLE: begin
          // Words offered while busy or off the cycle edge are ignored without notice.
          if (instr_valid_in) begin
            st_nxt.word = instr_word_in;
            st_nxt.op = decode(instr_word_in);
            st_nxt.state = RRE_EXEC;
            st_nxt.ready = 1'b0;
          end
        end
        RRE_EXEC: begin
          unique case (st_r.op)
            RRE_IRQ_EXIT, RRE_SUB_EXIT, RRE_LIT_EXIT: begin
              st_nxt.pc = stack_r[top];
              st_nxt.pc_load = 1'b1;
              st_nxt.sp = top;
              if (st_r.op == RRE_IRQ_EXIT) begin
                // Only the enable bit changes; the other control bits pass through.
                st_nxt.irq_ctl = irq_control_reg_in;
                st_nxt.irq_ctl[`RRE_IRQ_EN_BIT] = 1'b1;
                st_nxt.irq_ctl_we = 1'b1;
              end
              if (st_r.op == RRE_LIT_EXIT) begin
                st_nxt.wreg = st_r.word[7:0];
                st_nxt.wreg_we = 1'b1;
              end
              // Second cycle flushes the fetched word; no status flag moves.
              st_nxt.state = RRE_SECOND;
            end
            RRE_ROT: begin
              // The file address has stood since the clock after the take, so the read has settled; the
              // carry is taken from the flag as it stands at this edge.
              st_nxt.carry = rot[8];
              st_nxt.carry_we = 1'b1;
              if (st_r.word[`RRE_DEST_BIT]) begin
                st_nxt.faddr = st_r.word[6:0];
                st_nxt.fdata = rot[7:0];
                st_nxt.fwe = 1'b1;
              end else begin
                st_nxt.wreg = rot[7:0];
                st_nxt.wreg_we = 1'b1;
              end
              st_nxt.state = RRE_IDLE;
              st_nxt.ready = 1'b1;
            end
            // Unknown words finish in one instruction cycle like a no-operation.
            default: begin
              st_nxt.state = RRE_IDLE;
              st_nxt.ready = 1'b1;
            end
          endcase
        end
        RRE_SECOND: begin
          // The word fetched behind a return is discarded here.
          st_nxt.state = RRE_IDLE;
          st_nxt.ready = 1'b1;
        end
        default: st_nxt.state = RRE_IDLE;
      endcase
    end
    // Present the file address from the second clock of the execute cycle so that the read data
    // used by the rotate has settled before its edge.
    if (st_r.state == RRE_EXEC && st_r.op == RRE_ROT) begin
      st_nxt.faddr = st_r.word[6:0];
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= '{
        state: RRE_IDLE,
        op: RRE_NONE,
        pc: `RRE_PC_RST,
        ready: 1'b1,
        default: '0
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  // The stack array has no reset; a pop reads the entry below the pointer whether or not it was pushed.
  always_ff @(posedge clk_in) begin
    if (push_in) begin
      stack_r[st_r.sp] <= push_pc_in;
    end
  end

  // Every output is a field of the state register.
  always_comb begin
    instr_ready_out = st_r.ready;
    pc_out = st_r.pc;
    pc_load_out = st_r.pc_load;
    wreg_out = st_r.wreg;
    wreg_we_out = st_r.wreg_we;
    file_addr_out = st_r.faddr;
    file_wr_data_out = st_r.fdata;
    file_we_out = st_r.fwe;
    carry_out = st_r.carry;
    carry_we_out = st_r.carry_we;
    irq_control_reg_out = st_r.irq_ctl;
    irq_control_we_out = st_r.irq_ctl_we;
    stack_ptr_out = st_r.sp;
    cycle_en_out = st_r.cyc_en;
  end
endmodule // rre_core
`default_nettype wire

// ==== verilog/rre_defs.svh ====
// Constants of the return and rotate execution unit.
// Included by the package and the design file; holds definitions only.
`ifndef RRE_DEFS_SVH
`define RRE_DEFS_SVH

`define RRE_WORD_W 14
`define RRE_PC_W 13
`define RRE_OSC_PER_CYC 4
`define RRE_IRQ_EN_BIT 7
`define RRE_DEST_BIT 7
// Opcode patterns of the four handled instructions.
`define RRE_OP_RETURN 14'h0008
`define RRE_OP_IRQ_EXIT 14'h0009
`define RRE_OP_LIT_HI 6'h34
`define RRE_OP_ROT_HI 6'h0d
`define RRE_PC_RST 13'h0000
`define RRE_STACK_DEPTH 16

`endif

// ==== verilog/rre_pkg.sv ====
// Types of the return and rotate execution unit.
// Assumes rre_defs.svh is on the include path.
`default_nettype none
`include "rre_defs.svh"
package rre_pkg;
  typedef enum logic [2:0] {RRE_NONE, RRE_IRQ_EXIT, RRE_SUB_EXIT, RRE_LIT_EXIT, RRE_ROT} rre_op_t;
  typedef enum logic [1:0] {RRE_IDLE, RRE_EXEC, RRE_SECOND} rre_state_t;
endpackage
`default_nettype wire

// ==== verification/rre_core_chk.sv ====
// Checker of rre_core port timing and results.
// Assumes one clock clk_in and the active-low asynchronous reset nrst_in.
`timescale 1ns/1ns
`default_nettype none
module rre_core_chk #(parameter int DEPTH = 16) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic instr_valid_in,
  input wire logic [7:0] file_rd_data_in,
  input wire logic carry_in,
  input wire logic [7:0] wreg_out,
  input wire logic [7:0] file_wr_data_out,
  input wire logic instr_ready_out,
  input wire logic pc_load_out,
  input wire logic wreg_we_out,
  input wire logic file_we_out,
  input wire logic carry_out,
  input wire logic carry_we_out,
  input wire logic [7:0] irq_control_reg_out,
  input wire logic irq_control_we_out,
  input wire logic [$clog2(DEPTH)-1:0] stack_ptr_out,
  input wire logic cycle_en_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  AST_CYC: assert property (
    cycle_en_out |=> !cycle_en_out [*3] ##1 cycle_en_out) else $error("cycle not 4 clocks");
  AST_RET: assert property (
    pc_load_out |-> !instr_ready_out [*4] ##1 instr_ready_out) else $error("return length");
  AST_FLAGS: assert property (
    pc_load_out |-> !carry_we_out && !file_we_out) else $error("return touched flags");
  AST_IRQ_EN: assert property (
    irq_control_we_out |-> irq_control_reg_out[7] && pc_load_out) else $error("enable bit");
  AST_POP: assert property (
    pc_load_out |-> stack_ptr_out == $past(stack_ptr_out) - 1'b1) else $error("pop pointer");
  AST_ROT: assert property (
    carry_we_out |-> instr_ready_out && !pc_load_out) else $error("rotate length");
  AST_DEST: assert property (
    file_we_out |-> !wreg_we_out && carry_we_out) else $error("rotate destination");
  AST_CARRY: assert property (
    carry_we_out |-> carry_out == $past(file_rd_data_in[7])) else $error("carry out");
  AST_ROT_DATA: assert property (
    carry_we_out |-> (file_we_out ? file_wr_data_out : wreg_out) ==
      {$past(file_rd_data_in[6:0]), $past(carry_in)}) else $error("rotate result");
  AST_TAKE: assert property (
    cycle_en_out && instr_ready_out && instr_valid_in |=> !instr_ready_out) else $error("take");
  cover property (irq_control_we_out);
  cover property (file_we_out);
  cover property (wreg_we_out && pc_load_out);
  cover property (carry_we_out && wreg_we_out);
endmodule // rre_core_chk
bind rre_core rre_core_chk #(.DEPTH(DEPTH)) u_chk (
  .clk_in(clk_in),
  .nrst_in(nrst_in),
  .instr_valid_in(instr_valid_in),
  .file_rd_data_in(file_rd_data_in),
  .carry_in(carry_in),
  .wreg_out(wreg_out),
  .file_wr_data_out(file_wr_data_out),
  .instr_ready_out(instr_ready_out),
  .pc_load_out(pc_load_out),
  .wreg_we_out(wreg_we_out),
  .file_we_out(file_we_out),
  .carry_out(carry_out),
  .carry_we_out(carry_we_out),
  .irq_control_reg_out(irq_control_reg_out),
  .irq_control_we_out(irq_control_we_out),
  .stack_ptr_out(stack_ptr_out),
  .cycle_en_out(cycle_en_out)
);
`default_nettype wire

// ==== verification/rre_core_tb.sv ====
// Testbench of rre_core: a table of rotates, then returns and a reset.
// Assumes rre_pkg, rre_defs.svh and the checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module rre_core_tb;
  import rre_pkg::*;
  logic clk_in, nrst_in, instr_valid_in, push_in, carry_in, instr_ready_out, pc_load_out;
  logic wreg_we_out, file_we_out, carry_out, carry_we_out, irq_control_we_out, cycle_en_out;
  logic [13:0] instr_word_in;
  logic [12:0] push_pc_in, pc_out;
  logic [7:0] file_rd_data_in, irq_control_reg_in, wreg_out, file_wr_data_out;
  logic [7:0] irq_control_reg_out;
  logic [7:0] mem [128];
  logic [6:0] file_addr_out;
  logic [3:0] stack_ptr_out;
  int error_cnt, checks_done;
  // Row: word, carry in, file value, expected result, expected carry.
  logic [31:0] rows [4] = '{{14'h0d7f, 1'b0, 8'he6, 8'hcc, 1'b1},
    {14'h0d80, 1'b1, 8'h01, 8'h03, 1'b0}, {14'h0dff, 1'b1, 8'h80, 8'h01, 1'b1},
    {14'h0d10, 1'b1, 8'hff, 8'hff, 1'b1}};
  logic [13:0] rw [3] = '{14'h0009, 14'h0008, 14'h345a};
  assign file_rd_data_in = mem[file_addr_out];
  rre_core dut (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .instr_valid_in(instr_valid_in),
    .instr_word_in(instr_word_in),
    .push_in(push_in),
    .push_pc_in(push_pc_in),
    .file_rd_data_in(file_rd_data_in),
    .carry_in(carry_in),
    .irq_control_reg_in(irq_control_reg_in),
    .instr_ready_out(instr_ready_out),
    .pc_out(pc_out),
    .pc_load_out(pc_load_out),
    .wreg_out(wreg_out),
    .wreg_we_out(wreg_we_out),
    .file_addr_out(file_addr_out),
    .file_wr_data_out(file_wr_data_out),
    .file_we_out(file_we_out),
    .carry_out(carry_out),
    .carry_we_out(carry_we_out),
    .irq_control_reg_out(irq_control_reg_out),
    .irq_control_we_out(irq_control_we_out),
    .stack_ptr_out(stack_ptr_out),
    .cycle_en_out(cycle_en_out)
  );
  initial begin
    clk_in = 0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic chk(logic [15:0] g, logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Returns after the strobes of the instruction can be sampled.
  task automatic issue(logic [13:0] w, logic c, logic [7:0] m);
    int n;
    @(posedge clk_in);
    instr_word_in <= w;
    carry_in <= c;
    mem[w[6:0]] <= m;
    instr_valid_in <= 1;
    n = 0;
    do @(negedge clk_in); while (!(cycle_en_out && instr_ready_out) && ++n < 20);
    if (!(cycle_en_out && instr_ready_out)) begin
      error_cnt++;
      $display("mismatch at %0t: word never taken", $time);
    end
    @(posedge clk_in);
    instr_valid_in <= 0;
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  task automatic push(logic [12:0] pc);
    @(posedge clk_in);
    push_pc_in <= pc;
    push_in <= 1;
    @(posedge clk_in);
    push_in <= 0;
  endtask
  initial begin
    #50000;
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end
  initial begin
    {nrst_in, instr_valid_in, push_in, carry_in, instr_word_in, push_pc_in} = '0;
    irq_control_reg_in = 8'h15;
    repeat (5) @(posedge clk_in);
    nrst_in <= 1;
    foreach (rows[i]) begin
      issue(rows[i][31:18], rows[i][17], rows[i][16:9]);
      chk({pc_load_out, file_we_out, wreg_we_out, carry_we_out, carry_out},
        {1'b0, rows[i][25], !rows[i][25], 1'b1, rows[i][0]});
      chk(rows[i][25] ? file_wr_data_out : wreg_out, rows[i][8:1]);
      if (rows[i][25]) chk(file_addr_out, rows[i][24:18]);
      chk(instr_ready_out, 1'b1);
      $display("rotate row %0d done", i);
    end
    foreach (rw[i]) begin
      push(13'h1abc ^ 13'(i));
      issue(rw[i], 1'b0, 8'h00);
      chk({pc_load_out, wreg_we_out, irq_control_we_out, carry_we_out, file_we_out,
        stack_ptr_out}, {1'b1, rw[i][13:8] == 6'h34, rw[i] == 14'h9, 6'h0});
      chk(instr_ready_out, 1'b0);
      chk(pc_out, 13'h1abc ^ 13'(i));
      if (rw[i] == 14'h9) chk(irq_control_reg_out, 8'h95);
      chk(wreg_out, (rw[i][13:8] == 6'h34) ? rw[i][7:0] : 8'hff);
      $display("return %0d done", i);
    end
    issue(14'h0000, 1'b0, 8'h00);
    chk({pc_load_out, wreg_we_out, file_we_out, carry_we_out}, 4'h0);
    chk({irq_control_we_out, instr_ready_out}, 2'h1);
    $display("idle word test done");
    push(13'h0001);
    @(posedge clk_in);
    nrst_in <= 0;
    @(negedge clk_in);
    chk({instr_ready_out, pc_load_out, stack_ptr_out}, 6'h20);
    @(posedge clk_in);
    nrst_in <= 1;
    issue(14'h0d80, 1'b0, 8'h81);
    chk({file_we_out, file_wr_data_out, carry_out}, {1'b1, 8'h02, 1'b1});
    $display("reset test done");
    test_done();
  end
endmodule // rre_core_tb
`default_nettype wire
